// *** rtl/spc_top.sv ***
// Stepper coil PWM, flyback capture timer and port logic behind AXI4-Lite registers.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spc_defines.svh"
module spc_top #(
  parameter int NCH = 2,
  parameter int DW  = 11
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [2*NCH-1:0] pin_in,
  output logic [2*NCH-1:0]      pin_out,
  output logic [2*NCH-1:0]      pin_oe,
  output logic [2*NCH-1:0]      pin_pull_en,
  output logic [2*NCH-1:0]      pin_pull_up,
  output logic                  capture_irq
);
  import spc_pkg::*;
  localparam int NP = 2 * NCH;

  //----------------------------------------------------------------------------
  // Registers and state
  //----------------------------------------------------------------------------
  logic [1:0]    pre_reg;
  logic          fast_reg;
  logic          ovf_reg;
  logic          pol_reg;
  logic [DW-1:0] per_reg;
  logic [3:0]    ctl_reg [NCH];
  logic [DW-1:0] duty_reg [NCH];
  logic [15:0]   cap_reg [NCH];
  logic [NCH-1:0] side_reg, ios_reg, flag_reg, ie_reg, prev_reg;
  logic [NP-1:0] edge_reg, ddr_reg, dat_reg, pe_reg, ps_reg;
  logic          ten_reg;
  logic [2:0]    tpr_reg;
  logic [15:0]   tcnt_reg;
  logic [6:0]    tdiv_reg;
  logic [2:0]    mdiv_reg;
  logic [DW-1:0] mcnt_reg;
  logic          aw_got_reg, w_got_reg;
  logic [7:0]    aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          bvalid_next, rvalid_next, aw_got_next, w_got_next;

  //----------------------------------------------------------------------------
  // AXI4-Lite handshakes
  //----------------------------------------------------------------------------
  logic        aw_take, w_take, ar_take, do_wr, wr_hit;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data, wr_mask, wm, wv, wr_old;
  logic [3:0]  wr_strb;
  logic [32:0] rd_res, wr_res;

  // Address and data may arrive in either order; the write fires once both are held.
  assign aw_take     = s_axi_awvalid & s_axi_awready;
  assign w_take      = s_axi_wvalid & s_axi_wready;
  assign ar_take     = s_axi_arvalid & s_axi_arready;
  assign do_wr       = (aw_got_reg | aw_take) & (w_got_reg | w_take) & ~s_axi_bvalid;
  assign wr_addr     = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data     = w_got_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb     = w_got_reg ? w_strb_reg : s_axi_wstrb;
  assign aw_got_next = (aw_got_reg | aw_take) & ~do_wr;
  assign w_got_next  = (w_got_reg | w_take) & ~do_wr;
  assign bvalid_next = do_wr | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign wr_mask     = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wm          = wr_data & wr_mask;
  assign wv          = (wr_old & ~wr_mask) | wm;
  assign wr_old      = wr_res[31:0];
  assign wr_hit      = wr_res[32];

  // Channel state and handshake outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      aw_got_reg    <= aw_got_next;
      w_got_reg     <= w_got_next;
      s_axi_awready <= ~aw_got_next & ~bvalid_next;
      s_axi_wready  <= ~w_got_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
    end
  end

  // Held request payloads and the answers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      w_data_reg  <= `SPC_RST_WORD;
      w_strb_reg  <= 4'h0;
      s_axi_bresp <= `SPC_RESP_OKAY;
      s_axi_rresp <= `SPC_RESP_OKAY;
      s_axi_rdata <= `SPC_RST_WORD;
    end else begin
      if (aw_take) aw_addr_reg <= s_axi_awaddr;
      if (w_take) w_data_reg <= s_axi_wdata;
      if (w_take) w_strb_reg <= s_axi_wstrb;
      if (do_wr) s_axi_bresp <= wr_hit ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      if (ar_take) s_axi_rresp <= rd_res[32] ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      if (ar_take) s_axi_rdata <= rd_res[31:0];
    end
  end

  //----------------------------------------------------------------------------
  // Register map
  //----------------------------------------------------------------------------
  // Returns the hit flag and the read value of one address.
  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    logic [32:0] r;
    logic        ix_ok;
    int          ix;
    r     = {1'b1, `SPC_RST_WORD};
    ix    = int'(a[4:2]);
    ix_ok = ix < NCH;
    case (a)
      `SPC_OFS_MCA:  r[7:0] = {ovf_reg, 4'h0, fast_reg, pre_reg};
      `SPC_OFS_MCB:  r[0] = pol_reg;
      `SPC_OFS_PER:  r[DW-1:0] = per_reg;
      `SPC_OFS_IOS:  r[NCH-1:0] = ios_reg;
      `SPC_OFS_EDGE: r[NP-1:0] = edge_reg;
      `SPC_OFS_TCNT: r[15:0] = tcnt_reg;
      `SPC_OFS_TSCA: r[`SPC_TEN_BIT] = ten_reg;
      `SPC_OFS_TPR:  r[2:0] = tpr_reg;
      `SPC_OFS_FLAG: r[NCH-1:0] = flag_reg;
      `SPC_OFS_IE:   r[NCH-1:0] = ie_reg;
      `SPC_OFS_DDR:  r[NP-1:0] = ddr_reg;
      `SPC_OFS_DAT:  r[NP-1:0] = dat_reg;
      `SPC_OFS_PE:   r[NP-1:0] = pe_reg;
      `SPC_OFS_PS:   r[NP-1:0] = ps_reg;
      `SPC_OFS_PIN:  r[NP-1:0] = pin_in;
      default: begin
        r[32] = ix_ok && (a[1:0] == 2'b00);
        if (r[32] && a[7:5] == `SPC_RGN_CTL) r[7:0] = {2'b00, ctl_reg[ix][3:2], 2'b00, ctl_reg[ix][1:0]};
        else if (r[32] && a[7:5] == `SPC_RGN_DUTY) r[15:0] = 16'({side_reg[ix], 15'(duty_reg[ix])});
        else if (r[32] && a[7:5] == `SPC_RGN_CAP) r[15:0] = cap_reg[ix];
        else r[32] = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Read and write lookups share the same map.
  always_comb rd_res = rd_mux(s_axi_araddr);
  always_comb wr_res = rd_mux(wr_addr);

  // Write strobes per register.
  logic we_mca, we_mcb, we_per, we_ios, we_edge, we_tsca, we_tpr, we_flag, we_ie;
  logic we_ddr, we_dat, we_pe, we_ps;
  assign we_mca  = do_wr & (wr_addr == `SPC_OFS_MCA);
  assign we_mcb  = do_wr & (wr_addr == `SPC_OFS_MCB);
  assign we_per  = do_wr & (wr_addr == `SPC_OFS_PER);
  assign we_ios  = do_wr & (wr_addr == `SPC_OFS_IOS);
  assign we_edge = do_wr & (wr_addr == `SPC_OFS_EDGE);
  assign we_tsca = do_wr & (wr_addr == `SPC_OFS_TSCA);
  assign we_tpr  = do_wr & (wr_addr == `SPC_OFS_TPR);
  assign we_flag = do_wr & (wr_addr == `SPC_OFS_FLAG);
  assign we_ie   = do_wr & (wr_addr == `SPC_OFS_IE);
  assign we_ddr  = do_wr & (wr_addr == `SPC_OFS_DDR);
  assign we_dat  = do_wr & (wr_addr == `SPC_OFS_DAT);
  assign we_pe   = do_wr & (wr_addr == `SPC_OFS_PE);
  assign we_ps   = do_wr & (wr_addr == `SPC_OFS_PS);

  // Plain configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pre_reg, fast_reg, pol_reg, per_reg, ios_reg, edge_reg} <= '0;
      {ten_reg, tpr_reg, ie_reg, ddr_reg, dat_reg, pe_reg, ps_reg} <= '0;
    end else begin
      if (we_mca) pre_reg <= wv[`SPC_MCA_PRE_LSB +: 2];
      if (we_mca) fast_reg <= wv[`SPC_MCA_FAST_BIT];
      if (we_mcb) pol_reg <= wv[`SPC_MCB_POL_BIT];
      if (we_per) per_reg <= wv[DW-1:0];
      if (we_ios) ios_reg <= wv[NCH-1:0];
      if (we_edge) edge_reg <= wv[NP-1:0];
      if (we_tsca) ten_reg <= wv[`SPC_TEN_BIT];
      if (we_tpr) tpr_reg <= wv[2:0];
      if (we_ie) ie_reg <= wv[NCH-1:0];
      if (we_ddr) ddr_reg <= wv[NP-1:0];
      if (we_dat) dat_reg <= wv[NP-1:0];
      if (we_pe) pe_reg <= wv[NP-1:0];
      if (we_ps) ps_reg <= wv[NP-1:0];
    end
  end

  //----------------------------------------------------------------------------
  // Motor counter
  //----------------------------------------------------------------------------
  logic [2:0] mmask;
  logic       mtick, mwrap, mbnd;
  assign mmask = 3'((4'h1 << pre_reg) - 4'h1);
  assign mtick = (mdiv_reg & mmask) == mmask;
  assign mwrap = ({1'b0, mcnt_reg} + {{DW{1'b0}}, 1'b1}) >= {1'b0, per_reg};
  assign mbnd  = mtick & mwrap;

  // Divider, period counter and overflow flag; a new overflow wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdiv_reg <= 3'h0;
      mcnt_reg <= '0;
      ovf_reg  <= 1'b0;
    end else begin
      mdiv_reg <= mdiv_reg + 3'h1;
      if (mtick) mcnt_reg <= mwrap ? '0 : mcnt_reg + 1'b1;
      ovf_reg <= mbnd | (ovf_reg & ~(we_mca & wm[`SPC_MCA_OVF_BIT]));
    end
  end

  //----------------------------------------------------------------------------
  // Timer counter
  //----------------------------------------------------------------------------
  logic [6:0] tmask;
  logic       ttick;
  assign tmask = 7'((8'h01 << tpr_reg) - 8'h01);
  assign ttick = ten_reg & ((tdiv_reg & tmask) == tmask);

  // Prescaler and free-running count, stopped while the run bit is clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdiv_reg <= 7'h00;
      tcnt_reg <= 16'h0000;
    end else begin
      if (ten_reg) tdiv_reg <= tdiv_reg + 7'h01;
      if (ttick) tcnt_reg <= tcnt_reg + 16'h0001;
    end
  end

  //----------------------------------------------------------------------------
  // Channels, capture and pin ownership
  //----------------------------------------------------------------------------
  logic [NCH-1:0] cap_hit, cap_own, cin;
  logic [NP-1:0]  mot_oe, mot_out, tmr_own, oe_next;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    spc_chan_if #(.DW(DW)) ci();
    logic [3:0] ctl_wv;
    logic       we_ctl, we_duty, we_cap;
    assign ctl_wv     = {wv[`SPC_CTL_ALIGN_LSB +: 2], wv[`SPC_CTL_MODE_LSB +: 2]};
    assign we_ctl     = do_wr & (wr_addr == 8'({`SPC_RGN_CTL, 3'(i), 2'b00}));
    assign we_duty    = do_wr & (wr_addr == 8'({`SPC_RGN_DUTY, 3'(i), 2'b00}));
    assign we_cap     = do_wr & (wr_addr == 8'({`SPC_RGN_CAP, 3'(i), 2'b00}));
    assign ci.clk     = aclk;
    assign ci.rst_n   = aresetn;
    assign ci.mode    = spc_mode_type'(ctl_reg[i][1:0]);
    assign ci.align   = spc_align_type'(ctl_reg[i][3:2]);
    assign ci.side    = side_reg[i];
    assign ci.pol     = pol_reg;
    assign ci.boundary = mbnd;
    assign ci.period  = per_reg;
    assign ci.count   = mcnt_reg;
    assign ci.duty    = fast_reg ? DW'(duty_reg[i][8:2]) : duty_reg[i];
    spc_chan #(.DW(DW)) u_chan (.ch(ci.chan));

    // Motor pins, then the capture input on the minus pin.
    assign mot_oe[2*i]    = ci.oe_m;
    assign mot_oe[2*i+1]  = ci.oe_p;
    assign mot_out[2*i]   = ci.drv_m;
    assign mot_out[2*i+1] = ci.drv_p;
    assign cin[i]         = pin_in[2*i];
    assign cap_own[i]     = ten_reg & ~ios_reg[i] & (|edge_reg[2*i +: 2]);
    assign tmr_own[2*i]   = cap_own[i];
    assign tmr_own[2*i+1] = 1'b0;
    assign cap_hit[i]     = cap_own[i] & ((edge_reg[2*i] & cin[i] & ~prev_reg[i]) |
                            (edge_reg[2*i+1] & ~cin[i] & prev_reg[i]));

    // Per-channel control, duty and capture latch.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_reg[i]  <= 4'h0;
        duty_reg[i] <= '0;
        side_reg[i] <= 1'b0;
        cap_reg[i]  <= 16'h0000;
      end else begin
        if (we_ctl) ctl_reg[i] <= ctl_wv;
        if (we_duty) duty_reg[i] <= wv[DW-1:0];
        if (we_duty) side_reg[i] <= wv[`SPC_DUTY_SIDE_BIT];
        if (cap_hit[i]) cap_reg[i] <= tcnt_reg;
        else if (we_cap) cap_reg[i] <= wv[15:0];
      end
    end
  end

  // Motor first, then timer capture, then the port decides each pin.
  assign oe_next = mot_oe | (~mot_oe & ~tmr_own & ddr_reg);

  // Pin, flag and interrupt outputs; a capture wins over a flag clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg    <= '0;
      flag_reg    <= '0;
      capture_irq <= 1'b0;
      pin_out     <= '0;
      pin_oe      <= '0;
      pin_pull_en <= '0;
      pin_pull_up <= '0;
    end else begin
      prev_reg    <= cin;
      flag_reg    <= cap_hit | (flag_reg & ~({NCH{we_flag}} & wm[NCH-1:0]));
      capture_irq <= |(flag_reg & ie_reg);
      pin_out     <= (mot_oe & mot_out) | (~mot_oe & dat_reg);
      pin_oe      <= oe_next;
      pin_pull_en <= pe_reg & ~oe_next;
      pin_pull_up <= ps_reg;
    end
  end

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ovf_flag_set_a: assert property (mbnd |=> ovf_reg)
    else $error("Overflow flag missed a period end.");
  period_wrap_a: assert property (mbnd |=> mcnt_reg == '0)
    else $error("Motor counter did not restart at the period end.");
  tcnt_step_a: assert property (ttick |=> tcnt_reg == $past(tcnt_reg) + 16'h0001)
    else $error("Timer counter did not step on a timer tick.");
  tcnt_halt_a: assert property (!ten_reg |=> $stable(tcnt_reg))
    else $error("Timer counter moved while stopped.");
  tcnt_rate_a: assert property ((ttick && tpr_reg == 3'h1) ##1 (ten_reg && tpr_reg == 3'h1) |->
    !ttick ##1 (ttick || !ten_reg || tpr_reg != 3'h1))
    else $error("Timer prescale by two ticked at the wrong rate.");
  cap_copy_a: assert property (cap_hit[0] |=> cap_reg[0] == $past(tcnt_reg))
    else $error("Capture latch did not take the counter.");
  cap_flag_a: assert property (cap_hit[0] |=> flag_reg[0] ##1 (capture_irq || !$past(ie_reg[0])))
    else $error("Capture flag or interrupt request wrong.");
  flag_clear_a: assert property ((we_flag && wm[0] && !cap_hit[0]) |=> !flag_reg[0])
    else $error("Written one did not clear the flag.");
  motor_owns_a: assert property (mot_oe[0] |=> pin_oe[0] && pin_out[0] == $past(mot_out[0]))
    else $error("Motor did not own its pin.");
  pull_input_a: assert property (pin_oe[0] |-> !pin_pull_en[0])
    else $error("Pull enabled on a driven pin.");

  cover_capture_c: cover property (cap_hit[0] ##1 flag_reg[0]);
  cover_overflow_c: cover property (mbnd ##1 ovf_reg);
  cover_irq_c: cover property (capture_irq);
endmodule
`default_nettype wire

// *** shared/spc_defines.svh ***
// Register offsets, field positions and reset values of the stepper coil block.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_OFS_MCA       8'h00
`define SPC_OFS_MCB       8'h04
`define SPC_OFS_PER       8'h08
`define SPC_OFS_IOS       8'h0C
`define SPC_OFS_EDGE      8'h10
`define SPC_OFS_TCNT      8'h14
`define SPC_OFS_TSCA      8'h18
`define SPC_OFS_TPR       8'h1C
`define SPC_OFS_FLAG      8'h20
`define SPC_OFS_IE        8'h24
`define SPC_OFS_DDR       8'h28
`define SPC_OFS_DAT       8'h2C
`define SPC_OFS_PE        8'h30
`define SPC_OFS_PS        8'h34
`define SPC_OFS_PIN       8'h38
`define SPC_RGN_CTL       3'h2
`define SPC_RGN_DUTY      3'h3
`define SPC_RGN_CAP       3'h4
`define SPC_MCA_PRE_LSB   0
`define SPC_MCA_FAST_BIT  2
`define SPC_MCA_OVF_BIT   7
`define SPC_MCB_POL_BIT   0
`define SPC_CTL_MODE_LSB  0
`define SPC_CTL_ALIGN_LSB 4
`define SPC_DUTY_SIDE_BIT 15
`define SPC_TEN_BIT       7
`define SPC_RST_WORD      32'h0000_0000
`define SPC_RESP_OKAY     2'h0
`define SPC_RESP_SLVERR   2'h2
`endif

// *** shared/spc_pkg.sv ***
// Types shared by the stepper coil block.
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_HALF_M = 2'b00,
    SPC_HALF_P = 2'b01,
    SPC_FULL   = 2'b10,
    SPC_DUAL   = 2'b11
  } spc_mode_type;
  typedef enum logic [1:0] {
    SPC_OFF    = 2'b00,
    SPC_LEFT   = 2'b01,
    SPC_RIGHT  = 2'b10,
    SPC_CENTER = 2'b11
  } spc_align_type;
endpackage

// *** shared/spc_chan_if.sv ***
// Interface between the register core and one coil channel.
`timescale 1ns/1ns
`default_nettype none
interface spc_chan_if #(parameter int DW = 11);
  logic                  clk;
  logic                  rst_n;
  spc_pkg::spc_mode_type  mode;
  spc_pkg::spc_align_type align;
  logic                  side;
  logic                  pol;
  logic                  boundary;
  logic [DW-1:0]         duty;
  logic [DW-1:0]         period;
  logic [DW-1:0]         count;
  logic                  enabled;
  logic                  drv_m;
  logic                  drv_p;
  logic                  oe_m;
  logic                  oe_p;
  modport ctl (output clk, rst_n, mode, align, side, pol, boundary, duty, period, count,
               input enabled, drv_m, drv_p, oe_m, oe_p);
  modport chan (input clk, rst_n, mode, align, side, pol, boundary, duty, period, count,
                output enabled, drv_m, drv_p, oe_m, oe_p);
endinterface
`default_nettype wire

// *** rtl/spc_chan.sv ***
// One coil channel: alignment compare, polarity, output mode and deferred release.
`timescale 1ns/1ns
`default_nettype none
module spc_chan #(
  parameter int DW = 11
) (
  spc_chan_if.chan ch
);
  import spc_pkg::*;

  spc_align_type align_reg;
  logic [DW+1:0] cnt2;
  logic [DW+1:0] dty;
  logic [DW+1:0] per;
  logic          lft;
  logic          rgt;
  logic          ctr;
  logic          act;
  logic          pwm;
  logic          other;
  logic          on_p;

  // Alignment takes effect at once, but a release waits for the period boundary.
  always_ff @(posedge ch.clk) begin
    if (!ch.rst_n) begin
      align_reg <= SPC_OFF;
    end else if (ch.align != SPC_OFF) begin
      align_reg <= ch.align;
    end else if (ch.boundary) begin
      align_reg <= SPC_OFF;
    end
  end

  // Compare windows for the three alignments.
  assign cnt2 = {1'b0, ch.count, 1'b0};
  assign dty  = {2'b00, ch.duty};
  assign per  = {2'b00, ch.period};
  assign lft  = ch.count < ch.duty;
  assign rgt  = ({2'b00, ch.count} + dty) >= per;
  assign ctr  = ((cnt2 + dty) >= per) && (cnt2 < (per + dty));
  assign act  = (align_reg == SPC_LEFT) ? lft :
                (align_reg == SPC_RIGHT) ? rgt :
                (align_reg == SPC_CENTER) ? ctr : 1'b0;

  // Active level follows the polarity bit; the other pin rests at the inactive level, or in dual mode carries the complement.
  assign pwm   = act ? ch.pol : ~ch.pol;
  assign other = (ch.mode == SPC_DUAL) ? ~pwm : ~ch.pol;
  assign on_p  = (ch.mode == SPC_HALF_P) || ((ch.mode[1]) && ch.side);

  // Pin steering per output mode.
  assign ch.enabled = align_reg != SPC_OFF;
  assign ch.oe_m    = ch.enabled && (ch.mode != SPC_HALF_P);
  assign ch.oe_p    = ch.enabled && (ch.mode != SPC_HALF_M);
  assign ch.drv_m   = on_p ? other : pwm;
  assign ch.drv_p   = on_p ? pwm : other;

  release_at_bnd_a: assert property (@(posedge ch.clk) disable iff (!ch.rst_n)
    $fell(ch.enabled) |-> $past(ch.boundary))
    else $error("Channel released away from a period boundary.");
  hold_to_bnd_a: assert property (@(posedge ch.clk) disable iff (!ch.rst_n)
    (ch.enabled && ch.align == SPC_OFF && !ch.boundary) |=> ch.enabled)
    else $error("Channel released before the period boundary.");
  cover_release_c: cover property (@(posedge ch.clk) disable iff (!ch.rst_n) $fell(ch.enabled));
endmodule
`default_nettype wire

// *** verification/spc_coil_model.sv ***
// Coil model that resolves the shared pin levels seen by the block.
`timescale 1ns/1ns
`default_nettype none
module spc_coil_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pin_pull_en,
  input  wire logic [3:0] pin_pull_up,
  input  wire logic [3:0] flyback,
  output logic [3:0]      pin_in
);
  // A driven pin follows the block, a pulled pin its pull, a free pin the coil voltage.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pull_en[i] ? pin_pull_up[i] : flyback[i]);
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the stepper coil block.
`timescale 1ns/1ns
`default_nettype none
`include "spc_defines.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_irq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF, pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_up, flyback = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic [15:0] c1;
  int n_mismatch = 0, tests_run = 0, cyc = 0, r1, cnt;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} spc_row_type;
  spc_row_type rows [6] = '{'{8'h04, 32'h1, 32'h1, 2'h0}, '{8'h08, 32'hFFFF, 32'h7FF, 2'h0},
    '{8'h1C, 32'hF, 32'h7, 2'h0}, '{8'h10, 32'hF, 32'hF, 2'h0}, '{8'h64, 32'hFFFF, 32'h87FF, 2'h0},
    '{8'h3C, 32'h5, 32'h0, 2'h2}};
  spc_top uut (.*);
  spc_coil_model coil (.*);
  // The bus clock toggles every 50 ns, a period of 100 ns.
  always #50 aclk = ~aclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rd_data, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Counts driven-high cycles of one pin over forty cycles, after four settling cycles.
  task automatic hi(input int b);
    cnt = 0;
    repeat (4) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      cnt += int'(pin_out[b] & pin_oe[b]);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SPC_OFS_TCNT);
    `CHK("count_idle", 32'h0, rd_data)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK("bresp", rows[i].r, wrsp)
      rd(rows[i].a);
      `CHK("reg", rows[i].q, rd_data)
      `CHK("resp", rows[i].r, rsp)
    end
    wr(`SPC_OFS_DDR, 32'h2);
    wr(`SPC_OFS_DAT, 32'h2);
    wr(`SPC_OFS_PE, 32'h1);
    wr(`SPC_OFS_PS, 32'h1);
    rd(`SPC_OFS_PIN);
    `CHK("pin_oe", 4'h2, pin_oe)
    `CHK("pin_out", 1'b1, pin_out[1])
    `CHK("pin_lvl", 32'h3, rd_data)
    `CHK("pull_en", 4'h1, pin_pull_en)
    `CHK("pull_up", 4'h1, pin_pull_up)
    wr(`SPC_OFS_PE, 32'h0);
    wr(`SPC_OFS_EDGE, 32'h1);
    wr(`SPC_OFS_IE, 32'h1);
    wr(`SPC_OFS_TPR, 32'h1);
    wr(`SPC_OFS_TSCA, 32'h80);
    @(posedge aclk);
    flyback[0] <= 1'b1;
    r1 = cyc;
    rd(8'h80);
    c1 = rd_data[15:0];
    `CHK("irq", 1'b1, capture_irq)
    flyback[0] <= 1'b0;
    rd(8'h80);
    `CHK("fall_ignored", c1, rd_data[15:0])
    while (cyc < r1 + 200) @(posedge aclk);
    flyback[0] <= 1'b1;
    rd(8'h80);
    `CHK("cap_diff", 16'd100, rd_data[15:0] - c1)
    wr(`SPC_OFS_FLAG, 32'h0);
    rd(`SPC_OFS_FLAG);
    `CHK("flag_keep", 32'h1, rd_data)
    wr(`SPC_OFS_FLAG, 32'h1);
    rd(`SPC_OFS_FLAG);
    `CHK("flag_clr", 32'h0, rd_data)
    wr(`SPC_OFS_PER, 32'h4);
    wr(8'h60, 32'h1);
    wr(8'h40, 32'h12);
    hi(0);
    `CHK("pwm_minus", 10, cnt)
    rd(`SPC_OFS_MCA);
    `CHK("ovf_flag", 1'b1, rd_data[7])
    wr(8'h60, 32'h8001);
    hi(1);
    `CHK("pwm_plus", 10, cnt)
    wr(8'h40, 32'h2);
    repeat (8) @(posedge aclk);
    `CHK("release", 2'b10, pin_oe[1:0])
    wr(`SPC_OFS_MCA, 32'h1);
    wr(8'h40, 32'h23);
    hi(0);
    `CHK("pwm_dual", 30, cnt)
    hi(1);
    `CHK("pwm_right", 10, cnt)
    wr(`SPC_OFS_MCA, 32'h4);
    wr(8'h60, 32'h8);
    wr(8'h40, 32'h30);
    hi(0);
    `CHK("pwm_fast", 20, cnt)
    wr(`SPC_OFS_IOS, 32'h1);
    wr(`SPC_OFS_FLAG, 32'h1);
    repeat (8) @(posedge aclk);
    rd(`SPC_OFS_FLAG);
    `CHK("ios_blocks", 32'h0, rd_data)
    finish_test;
  end
  // Free cycle count for capture timing and the hang limit.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end
endmodule
`default_nettype wire
